// file: src/fps_defines.svh
// Timing constants and fixed settings of the fault protection supervisor
`ifndef FPS_DEFINES_SVH
`define FPS_DEFINES_SVH

`define FPS_CLK_MHZ          200
`define FPS_LIMIT_LONG_NS    2000
`define FPS_LIMIT_SHORT_NS   1000
`define FPS_P13_CHECK_NS     10000
`define FPS_RESTART_MS       1500
`define FPS_LIMIT_LONG_CYC   ((`FPS_LIMIT_LONG_NS * `FPS_CLK_MHZ) / 1000)
`define FPS_LIMIT_SHORT_CYC  ((`FPS_LIMIT_SHORT_NS * `FPS_CLK_MHZ) / 1000)
`define FPS_P13_CHECK_CYC    ((`FPS_P13_CHECK_NS * `FPS_CLK_MHZ) / 1000)
`define FPS_RESTART_CYC      (`FPS_RESTART_MS * 1000 * `FPS_CLK_MHZ)
`define FPS_PULSE_FAULT_CNT  3

`endif

// file: src/fps_pkg.sv
// Types shared by the fault protection supervisor
package fps_pkg;
	typedef enum logic [2:0] {
		FPS_ST_OFF     = 3'b000,
		FPS_ST_SETTLE  = 3'b001,
		FPS_ST_RUN     = 3'b011,
		FPS_ST_RESTART = 3'b010,
		FPS_ST_DRAIN   = 3'b110
	} fps_state_type;
endpackage : fps_pkg

// file: src/fps_pulse_counter.sv
// Counter of consecutive low-side pulses that end with a condition present
`timescale 1ns/10ps
module fps_pulse_counter #(
	parameter int unsigned LIMIT = 3
) (
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic rst_i,
	// Pulse events
	input  wire logic clear_i,
	input  wire logic pulse_end_i,
	input  wire logic cond_i,
	// Result
	output logic      trip_o
);
	logic [3:0] count_r;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			count_r <= 4'h0;
		end else if (clear_i) begin
			count_r <= 4'h0;
		end else if (pulse_end_i) begin
			if (!cond_i) begin
				count_r <= 4'h0;
			end else if (count_r < 4'(LIMIT)) begin
				count_r <= count_r + 4'h1;
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			trip_o <= 1'b0;
		end else begin
			trip_o <= !clear_i && pulse_end_i && cond_i && (count_r == 4'(LIMIT - 1));
		end
	end
endmodule : fps_pulse_counter

// file: src/fps_supervisor.sv
// Fault supervision of a flyback controller: shutdown, thermal and pin faults
//
// What this block does
// - Reference below power-good ends switching, lockout cycle
// - Held-low reference keeps repeating lockout, no switching
// - Over-temperature forces lockout cycles while still hot
// - Pin faults auto-recover; shorts mean to analog ground
// - Reduced variant omits discharge pin over-voltage check
// - First pulse too long with Si select: short
// - GaN select: limit 2 us or 1 us by resistor
// - Three consecutive over-current pulses flag open sense
// - Regulator pin settles before first low-side pulse
// - Regulator pin low after 10 us: lockout, no switching
// - Three consecutive regulator over-voltage pulses: lockout cycle
// - Shorted regulator pin: supply never on, stay disabled
// - Programming pins checked at turn-on for open/short
// - Programming pin fault: no switching, one lockout cycle
`timescale 1ns/10ps
`include "fps_defines.svh"
module fps_supervisor
	import fps_pkg::*;
#(
	parameter int unsigned RESTART_CYC = `FPS_RESTART_CYC,
	parameter bit          HAS_XCD_OVP = 1'b1
) (
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic rst_i,
	// Supply and reference comparators
	input  wire logic supply_on_i,
	input  wire logic supply_off_i,
	input  wire logic ref_good_i,
	input  wire logic over_temp_i,
	// Drive and sense comparators
	input  wire logic low_side_drive_i,
	input  wire logic driver_sel_si_i,
	input  wire logic demag_above_th_i,
	input  wire logic cs_over_ocp_i,
	input  wire logic sensing_regulator_low_i,
	input  wire logic sensing_regulator_ov_i,
	input  wire logic demag_program_pin_open_i,
	input  wire logic demag_program_pin_short_i,
	input  wire logic zero_volt_delay_pin_open_i,
	input  wire logic zero_volt_delay_pin_short_i,
	input  wire logic capacitor_discharge_pin_ov_i,
	// Controls and status
	output logic      switch_enable_o,
	output logic      force_supply_off_o,
	output logic      restart_active_o,
	output logic      cs_short_fault_o,
	output logic      cs_open_fault_o,
	output logic      p13_fault_o,
	output logic      prog_pin_fault_o
);
	fps_state_type state_r;
	logic          pwm_d_r;
	logic          first_r;
	logic          first_seen_r;
	logic [15:0]   on_cnt_r;
	logic [11:0]   settle_cnt_r;
	logic [31:0]   restart_cnt_r;
	logic          cs_open_trip;
	logic          p13_ov_trip;
	logic          pulse_end;
	logic          cs_short_hit;
	logic          lockout_ev;
	logic          delay_ev;
	logic [15:0]   limit_cyc;
	logic          settle_done;
	logic          xcd_ov;

	assign pulse_end = pwm_d_r && !low_side_drive_i;
	assign xcd_ov    = HAS_XCD_OVP && capacitor_discharge_pin_ov_i;

	// Si select uses the long limit; GaN picks by the resistor range
	always_comb begin
		if (driver_sel_si_i || demag_above_th_i) begin
			limit_cyc = 16'(`FPS_LIMIT_LONG_CYC);
		end else begin
			limit_cyc = 16'(`FPS_LIMIT_SHORT_CYC);
		end
	end

	assign settle_done = settle_cnt_r >= 12'(`FPS_P13_CHECK_CYC);
	assign cs_short_hit = (state_r == FPS_ST_RUN) && first_r && low_side_drive_i
		&& (on_cnt_r >= limit_cyc);
	assign delay_ev = cs_short_hit || cs_open_trip;
	assign lockout_ev = ((state_r == FPS_ST_RUN) &&
		(!ref_good_i || over_temp_i || p13_ov_trip || xcd_ov))
		|| ((state_r == FPS_ST_SETTLE) && settle_done &&
		(sensing_regulator_low_i || demag_program_pin_open_i || demag_program_pin_short_i
		|| zero_volt_delay_pin_open_i || zero_volt_delay_pin_short_i
		|| !ref_good_i || over_temp_i));

	// ------------------------------------------------------------
	// Consecutive pulse counters
	// ------------------------------------------------------------
	fps_pulse_counter #(.LIMIT(`FPS_PULSE_FAULT_CNT)) u_cs_open (
		.clock_i     (clock_i),
		.rst_i       (rst_i),
		.clear_i     (state_r != FPS_ST_RUN),
		.pulse_end_i (pulse_end),
		.cond_i      (cs_over_ocp_i),
		.trip_o      (cs_open_trip)
	);

	fps_pulse_counter #(.LIMIT(`FPS_PULSE_FAULT_CNT)) u_p13_ov (
		.clock_i     (clock_i),
		.rst_i       (rst_i),
		.clear_i     (state_r != FPS_ST_RUN),
		.pulse_end_i (pulse_end),
		.cond_i      (sensing_regulator_ov_i),
		.trip_o      (p13_ov_trip)
	);

	// ------------------------------------------------------------
	// Supply cycle state machine
	// ------------------------------------------------------------
	// A shorted regulator pin keeps supply_on low, so OFF is never left
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= FPS_ST_OFF;
		end else begin
			unique case (state_r)
				FPS_ST_OFF: begin
					if (supply_on_i) begin
						state_r <= FPS_ST_SETTLE;
					end
				end
				FPS_ST_SETTLE: begin
					if (supply_off_i || lockout_ev) begin
						state_r <= FPS_ST_DRAIN;
					end else if (settle_done) begin
						state_r <= FPS_ST_RUN;
					end
				end
				FPS_ST_RUN: begin
					if (delay_ev) begin
						state_r <= FPS_ST_RESTART;
					end else if (lockout_ev || supply_off_i) begin
						state_r <= FPS_ST_DRAIN;
					end
				end
				FPS_ST_RESTART: begin
					if (restart_cnt_r >= RESTART_CYC && supply_off_i) begin
						state_r <= FPS_ST_OFF;
					end
				end
				FPS_ST_DRAIN: begin
					if (supply_off_i) begin
						state_r <= FPS_ST_OFF;
					end
				end
				default: state_r <= FPS_ST_OFF;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Timers
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			settle_cnt_r <= 12'h000;
		end else if (state_r != FPS_ST_SETTLE) begin
			settle_cnt_r <= 12'h000;
		end else if (!settle_done) begin
			settle_cnt_r <= settle_cnt_r + 12'h001;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			restart_cnt_r <= 32'h0;
		end else if (state_r != FPS_ST_RESTART) begin
			restart_cnt_r <= 32'h0;
		end else if (restart_cnt_r < RESTART_CYC) begin
			restart_cnt_r <= restart_cnt_r + 32'h1;
		end
	end

	// Only the first pulse after each supply startup is timed
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pwm_d_r      <= 1'b0;
			first_seen_r <= 1'b0;
			first_r      <= 1'b0;
			on_cnt_r     <= 16'h0;
		end else begin
			pwm_d_r <= low_side_drive_i;
			if (state_r != FPS_ST_RUN) begin
				first_seen_r <= 1'b0;
				first_r      <= 1'b0;
				on_cnt_r     <= 16'h0;
			end else if (low_side_drive_i && !pwm_d_r && !first_seen_r) begin
				first_seen_r <= 1'b1;
				first_r      <= 1'b1;
				on_cnt_r     <= 16'h1;
			end else if (pulse_end) begin
				first_r <= 1'b0;
			end else if (first_r && low_side_drive_i && on_cnt_r != 16'hffff) begin
				on_cnt_r <= on_cnt_r + 16'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			switch_enable_o    <= 1'b0;
			force_supply_off_o <= 1'b0;
			restart_active_o   <= 1'b0;
		end else begin
			switch_enable_o    <= (state_r == FPS_ST_RUN) && !delay_ev && !lockout_ev;
			force_supply_off_o <= (state_r == FPS_ST_DRAIN);
			restart_active_o   <= (state_r == FPS_ST_RESTART);
		end
	end

	// Fault flags hold until the next supply start out of OFF
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cs_short_fault_o <= 1'b0;
			cs_open_fault_o  <= 1'b0;
			p13_fault_o      <= 1'b0;
			prog_pin_fault_o <= 1'b0;
		end else if (state_r == FPS_ST_OFF && supply_on_i) begin
			cs_short_fault_o <= 1'b0;
			cs_open_fault_o  <= 1'b0;
			p13_fault_o      <= 1'b0;
			prog_pin_fault_o <= 1'b0;
		end else begin
			if (cs_short_hit) begin
				cs_short_fault_o <= 1'b1;
			end
			if (cs_open_trip && state_r == FPS_ST_RUN) begin
				cs_open_fault_o <= 1'b1;
			end
			if ((state_r == FPS_ST_RUN && p13_ov_trip) ||
				(state_r == FPS_ST_SETTLE && settle_done && sensing_regulator_low_i)) begin
				p13_fault_o <= 1'b1;
			end
			if (state_r == FPS_ST_SETTLE && settle_done &&
				(demag_program_pin_open_i || demag_program_pin_short_i ||
				zero_volt_delay_pin_open_i || zero_volt_delay_pin_short_i)) begin
				prog_pin_fault_o <= 1'b1;
			end
		end
	end
endmodule : fps_supervisor

// file: verification/fps_power_model.sv
// Supply and power stage model that feeds the supervisor's supply comparators
`timescale 1ns/10ps
module fps_power_model #(
	parameter int DECAY  = 2500,
	parameter int CHARGE = 100
) (
	input  wire logic clock_i,
	input  wire logic switch_enable_i,
	input  wire logic short_i,
	output logic      supply_on_o,
	output logic      supply_off_o
);
	int cnt;
	initial begin
		supply_on_o = 0;
		supply_off_o = 1;
		cnt = 0;
	end
	// Supply only survives while switching recharges it
	always @(posedge clock_i) begin
		cnt <= cnt + 1;
		if (supply_on_o && switch_enable_i)
			cnt <= 0;
		else if (supply_on_o && cnt >= DECAY) begin
			supply_on_o <= 0;
			supply_off_o <= 1;
			cnt <= 0;
		end else if (!supply_on_o && cnt >= CHARGE && !short_i) begin
			supply_on_o <= 1;
			supply_off_o <= 0;
			cnt <= 0;
		end
	end
endmodule : fps_power_model

// file: verification/fps_supervisor_monitor.sv
// Assertion checker for the fault protection supervisor
`timescale 1ns/10ps
module fps_supervisor_monitor (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic supply_on_i,
	input wire logic ref_good_i,
	input wire logic over_temp_i,
	input wire logic switch_enable_o,
	input wire logic force_supply_off_o,
	input wire logic restart_active_o,
	input wire logic cs_short_fault_o,
	input wire logic cs_open_fault_o,
	input wire logic p13_fault_o,
	input wire logic prog_pin_fault_o
);
	int settle_r;
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// Saturates so a long run cannot wrap
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			settle_r <= 0;
		else if (!supply_on_i)
			settle_r <= 0;
		else if (settle_r < 3000)
			settle_r <= settle_r + 1;
	end
	a_ref_low_stop: assert property (!ref_good_i && switch_enable_o |-> ##[1:3] !switch_enable_o)
		else $error("switching kept with reference low");
	a_ref_held_off: assert property (!ref_good_i [*4] |-> !switch_enable_o)
		else $error("switching while reference held low");
	a_hot_stop: assert property (over_temp_i && switch_enable_o |-> ##[1:3] !switch_enable_o)
		else $error("switching kept while hot");
	a_settle_time: assert property ($rose(switch_enable_o) |-> settle_r >= 2000)
		else $error("switching before regulator settled");
	a_restart_no_drive: assert property (restart_active_o |-> !switch_enable_o)
		else $error("switching during restart delay");
	a_short_restart: assert property ($rose(cs_short_fault_o) |-> ##[0:2] restart_active_o)
		else $error("sense short without restart");
	a_open_restart: assert property ($rose(cs_open_fault_o) |-> ##[0:2] restart_active_o)
		else $error("sense open without restart");
	a_prog_no_switch: assert property (prog_pin_fault_o |-> !switch_enable_o)
		else $error("switching with programming pin fault");
	a_p13_lockout: assert property ($rose(p13_fault_o) |-> ##[0:2] force_supply_off_o)
		else $error("regulator pin fault without lockout");
endmodule : fps_supervisor_monitor

bind fps_supervisor fps_supervisor_monitor fps_supervisor_monitor_i (.clock_i, .rst_i,
	.supply_on_i, .ref_good_i, .over_temp_i, .switch_enable_o, .force_supply_off_o,
	.restart_active_o, .cs_short_fault_o, .cs_open_fault_o, .p13_fault_o, .prog_pin_fault_o);

// file: verification/fault_protection_supervisor_tb.sv
// Self-checking bench of the fault protection supervisor
`timescale 1ns/10ps
module fault_protection_supervisor_tb;
	logic clock_i = 0, rst_i = 1, supply_on_i, supply_off_i, ref_good_i = 1, over_temp_i = 0;
	logic low_side_drive_i = 0, driver_sel_si_i = 0, demag_above_th_i = 0, cs_over_ocp_i = 0;
	logic sensing_regulator_ov_i = 0, capacitor_discharge_pin_ov_i = 0, p13_short = 0;
	logic sensing_regulator_low_i, demag_program_pin_open_i, demag_program_pin_short_i;
	logic zero_volt_delay_pin_open_i, zero_volt_delay_pin_short_i, switch_enable_o;
	logic force_supply_off_o, restart_active_o, cs_short_fault_o, cs_open_fault_o;
	logic p13_fault_o, prog_pin_fault_o;
	logic lite_switch_enable_o, lite_force_supply_off_o;
	logic [4:0] pins = 5'h00;
	int errors = 0, cmp_count = 0, m, i, lim, t = 0;
	assign {sensing_regulator_low_i, zero_volt_delay_pin_short_i, zero_volt_delay_pin_open_i,
		demag_program_pin_short_i, demag_program_pin_open_i} = pins;
	fps_supervisor #(.RESTART_CYC(100)) fps_supervisor_i (.*);
	// Reduced variant shares every input; only its outputs differ
	fps_supervisor #(.RESTART_CYC(100), .HAS_XCD_OVP(1'b0)) fps_supervisor_lite_i (
		.clock_i                     (clock_i),
		.rst_i                       (rst_i),
		.supply_on_i                 (supply_on_i),
		.supply_off_i                (supply_off_i),
		.ref_good_i                  (ref_good_i),
		.over_temp_i                 (over_temp_i),
		.low_side_drive_i            (low_side_drive_i),
		.driver_sel_si_i             (driver_sel_si_i),
		.demag_above_th_i            (demag_above_th_i),
		.cs_over_ocp_i               (cs_over_ocp_i),
		.sensing_regulator_low_i     (sensing_regulator_low_i),
		.sensing_regulator_ov_i      (sensing_regulator_ov_i),
		.demag_program_pin_open_i    (demag_program_pin_open_i),
		.demag_program_pin_short_i   (demag_program_pin_short_i),
		.zero_volt_delay_pin_open_i  (zero_volt_delay_pin_open_i),
		.zero_volt_delay_pin_short_i (zero_volt_delay_pin_short_i),
		.capacitor_discharge_pin_ov_i(capacitor_discharge_pin_ov_i),
		.switch_enable_o             (lite_switch_enable_o),
		.force_supply_off_o          (lite_force_supply_off_o),
		.restart_active_o            (),
		.cs_short_fault_o            (),
		.cs_open_fault_o             (),
		.p13_fault_o                 (),
		.prog_pin_fault_o            ()
	);
	fps_power_model fps_power_model_i (.clock_i, .switch_enable_i(switch_enable_o),
		.short_i(p13_short), .supply_on_o(supply_on_i), .supply_off_o(supply_off_i));
	always #2.5 clock_i = ~clock_i;
	task automatic chk(string n, logic e, logic g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s exp %b got %b", n, e, g);
		end
	endtask : chk
	task automatic go_run();
		for (int k = 0; k < 8000 && switch_enable_o !== 1'b1; k++) @(negedge clock_i);
		chk("switch_enable_o", 1, switch_enable_o);
	endtask : go_run
	task automatic pulse(int len, bit cs, bit ov);
		low_side_drive_i = 1;
		cs_over_ocp_i = cs;
		sensing_regulator_ov_i = ov;
		repeat (len) @(negedge clock_i);
		low_side_drive_i = 0;
		repeat (4) @(negedge clock_i);
		cs_over_ocp_i = 0;
		sensing_regulator_ov_i = 0;
	endtask : pulse
	// Pulls the reference low to end a supply cycle
	task automatic drop();
		ref_good_i = 0;
		repeat (4) @(negedge clock_i);
		chk("switch_enable_o", 0, switch_enable_o);
		for (int k = 0; k < 5000 && supply_on_i; k++) @(negedge clock_i);
		ref_good_i = 1;
		$display("test %0d done", t++);
	endtask : drop
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	initial begin
		#600000;
		errors++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'ha961));
		repeat (12) @(negedge clock_i);
		rst_i = 0;
		for (m = 0; m < 6; m++) begin
			lim = (m % 3 == 2) ? 200 : 400;
			driver_sel_si_i = (m % 3 == 0);
			demag_above_th_i = (m % 3 == 1);
			go_run();
			pulse(m < 3 ? lim + 5 + $urandom % 20 : lim - 30 - $urandom % 20, 0, 0);
			chk("cs_short_fault_o", m < 3, cs_short_fault_o);
			chk("restart_active_o", m < 3, restart_active_o);
			drop();
		end
		for (m = 0; m < 4; m++) begin
			go_run();
			pulse(20 + $urandom % 50, 0, 0);
			for (i = 0; i < 5; i++) pulse(30, m[0] && (m > 1 || i != 2), !m[0] && (m > 1 || i != 2));
			chk("cs_open_fault_o", m == 3, cs_open_fault_o);
			chk("p13_fault_o", m == 2, p13_fault_o);
			chk("force_supply_off_o", m == 2, force_supply_off_o);
			drop();
		end
		for (m = 0; m < 5; m++) begin
			pins = 5'h01 << m;
			for (i = 0; i < 400 && !supply_on_i; i++) @(negedge clock_i);
			repeat (2010) @(negedge clock_i);
			chk("switch_enable_o", 0, switch_enable_o);
			chk("pin fault", 1, m == 4 ? p13_fault_o : prog_pin_fault_o);
			pins = 5'h00;
			drop();
		end
		go_run();
		over_temp_i = 1;
		repeat (5500) @(negedge clock_i);
		chk("switch_enable_o", 0, switch_enable_o);
		over_temp_i = 0;
		go_run();
		capacitor_discharge_pin_ov_i = 1;
		repeat (4) @(negedge clock_i);
		chk("force_supply_off_o", 1, force_supply_off_o);
		chk("lite_force_supply_off_o", 0, lite_force_supply_off_o);
		chk("lite_switch_enable_o", 1, lite_switch_enable_o);
		capacitor_discharge_pin_ov_i = 0;
		ref_good_i = 0;
		repeat (5500) @(negedge clock_i);
		chk("switch_enable_o", 0, switch_enable_o);
		p13_short = 1;
		drop();
		repeat (5500) @(negedge clock_i);
		chk("supply_on_i", 0, supply_on_i);
		chk("switch_enable_o", 0, switch_enable_o);
		end_of_test();
	end
endmodule : fault_protection_supervisor_tb
